// File: src/bms_defs.svh
// constants for the battery measurement scheduler and its host controller
//
// Operation
// [RQ1] charge integrates sense input, 250 ms, 16 bits
// [RQ2] continuous enable: new charge result each period
// [RQ3] conversion end sets done flag, drives alert
// [RQ4] single shot: one integration then done flag
// [RQ5] host: continuous off, single shot written one
// [RQ6] charge result signed 16 bits, 8.44 uV
// [RQ7] top bit set means negative charge code
// [RQ8] source select one: thermistors into temperature results
// [RQ9] source select zero: die sensor into results
// [RQ10] new source appears within 2 s interval
// [RQ11] temperature results are 14-bit converter codes
// [RQ12] extra die readings go to second, third
// [RQ13] cell codes summed, divided by four, 16 bits
// [RQ14] pack result weight 1.532 mV per count
// [RQ15] host scales pack as 4*gain*code plus offsets
// [RQ16] scheduler completes an update every 250 ms
// [RQ17] temperatures taken once every 2 seconds
// [RQ18] pack sum recomputed every 250 ms cycle
// [RQ19] host recomputes stack gain after 100 mV move
// [RQ20] host without correction uses stack gain one
// [RQ21] high then low read returns same sample
// [RQ22] single shot request clears itself on completion
// [RQ23] done flag holds until host clears it
`ifndef BMS_DEFS_SVH
`define BMS_DEFS_SVH

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define BMS_CLK_HZ      20000000
`define BMS_INTEG_MS    250
`define BMS_INTEG_CYC   ((`BMS_CLK_HZ / 1000) * `BMS_INTEG_MS)
`define BMS_TEMP_MS     2000
`define BMS_TEMP_TICKS  (`BMS_TEMP_MS / `BMS_INTEG_MS)
`define BMS_PACK_SHIFT  2

// ----------------------------------------------------------------------
// device register offsets (link side, byte wide)
// ----------------------------------------------------------------------
`define BMS_REG_STATUS  8'h00
`define BMS_REG_CTRL    8'h01
`define BMS_REG_CC_HI   8'h02
`define BMS_REG_TEMP3LO 8'h0B
`define BMS_WORD_CC     7'h01
`define BMS_WORD_PACK   7'h02
`define BMS_WORD_TEMP1  7'h03
`define BMS_WORD_TEMP2  7'h04
`define BMS_WORD_TEMP3  7'h05
`define BMS_ST_DONE     0
`define BMS_CT_CONT     0
`define BMS_CT_SHOT     1
`define BMS_CT_TSEL     2
`define BMS_CTRL_RST    3'h0
`define BMS_CC_MAX      32'sh00007FFF
`define BMS_CC_MIN      32'shFFFF8000

// ----------------------------------------------------------------------
// host controller apb map
// ----------------------------------------------------------------------
`define BMS_APB_CMD     12'h000
`define BMS_APB_STAT    12'h004
`define BMS_CMD_ADDR_LO 0
`define BMS_CMD_DATA_LO 8
`define BMS_CMD_WR      16
`define BMS_CMD_GO      17
`define BMS_STAT_BUSY   0
`define BMS_STAT_ALERT  1
`define BMS_STAT_RD_LO  8

`endif

// File: src/bms_device.sv
// measurement device end: charge counter, temperatures, pack sum
`include "bms_defs.svh"
`default_nettype none
module bms_device
    import bms_pkg::*;
#(
    parameter int unsigned INTEG_CYC = `BMS_INTEG_CYC
)
(
    input  wire logic             clk,        // system clock
    input  wire logic             srst,       // sync reset
    bms_link_if.dev               link,       // host register link
    input  wire logic             cc_bit,     // sense modulator bit
    input  wire bms_code_t [14:0] cell_code,  // converted cell codes
    input  wire bms_code_t [2:0]  therm_code, // thermistor codes
    input  wire bms_code_t [2:0]  die_code    // die sensor codes
);
    // ------------------------------------------------------------------
    // control and status
    // ------------------------------------------------------------------
    logic            charge_counter_continuous_enable;
    logic            charge_counter_single_shot;
    logic            temp_sel;
    logic            charge_sample_done_flag;
    logic            ack;
    bms_byte_t       rdata;
    bms_word_t       cc_result;
    bms_word_t       pack_sum_result;
    bms_word_t       temp_result [3];
    logic [2:0]      temp_slot_cnt;
    logic signed [31:0] cc_acc;
    bms_byte_t       shadow;
    logic [7:0]      shadow_addr;
    logic            shadow_ok;

    wire take     = link.req && !ack;
    wire do_write = take && link.wr;
    wire do_read  = take && !link.wr;
    wire wr_ctrl  = do_write && (link.addr == `BMS_REG_CTRL);
    wire wr_stat  = do_write && (link.addr == `BMS_REG_STATUS);
    wire clr_done = wr_stat && link.wdata[`BMS_ST_DONE];

    // ------------------------------------------------------------------
    // timers
    // ------------------------------------------------------------------
    logic sched_tick;
    logic cc_tick;
    wire  cc_run = charge_counter_continuous_enable
                   || charge_counter_single_shot;

    // free-running master period
    bms_tick #(.PERIOD(INTEG_CYC)) u_sched
    (
        .clk  (clk),
        .srst (srst),
        .en   (1'b1),
        .tick (sched_tick)  // RQ16
    );

    // integration window restarts whenever the counter is idle, so a
    // single shot started from idle gets a full window
    bms_tick #(.PERIOD(INTEG_CYC)) u_cc
    (
        .clk  (clk),
        .srst (srst),
        .en   (cc_run),
        .tick (cc_tick)     // RQ1
    );

    // ------------------------------------------------------------------
    // charge integration
    // ------------------------------------------------------------------
    function automatic bms_word_t cc_sat(input logic signed [31:0] v);
        if (v > `BMS_CC_MAX)
            return bms_word_t'(`BMS_CC_MAX);
        else if (v < `BMS_CC_MIN)
            return bms_word_t'(`BMS_CC_MIN);
        else
            return v[15:0];
    endfunction

    wire signed [31:0] cc_step = cc_bit ? 32'sh1 : -32'sh1;
    wire signed [31:0] next_cc_acc = cc_acc + cc_step;

    always_ff @(posedge clk)
    begin
        if (srst || !cc_run || cc_tick)
            cc_acc <= '0;
        else
            cc_acc <= next_cc_acc;
    end

    // two's complement result; saturation keeps sign instead of wrapping
    always_ff @(posedge clk)
    begin
        if (srst)
            cc_result <= '0;
        else if (cc_tick)
            cc_result <= cc_sat(next_cc_acc);  // RQ6 RQ7
    end

    // ------------------------------------------------------------------
    // control register, single shot and done flag
    // ------------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            {temp_sel, charge_counter_single_shot,
             charge_counter_continuous_enable} <= `BMS_CTRL_RST;
        end
        else if (wr_ctrl)
        begin
            // a host write beats the self clear in the same cycle
            charge_counter_continuous_enable <= link.wdata[`BMS_CT_CONT];
            charge_counter_single_shot       <= link.wdata[`BMS_CT_SHOT];
            temp_sel                         <= link.wdata[`BMS_CT_TSEL];
        end
        else if (cc_tick)
            charge_counter_single_shot <= 1'b0;  // RQ4 RQ22
    end

    // set wins over the host clear
    always_ff @(posedge clk)
    begin
        if (srst)
            charge_sample_done_flag <= 1'b0;
        else if (cc_tick)
            charge_sample_done_flag <= 1'b1;     // RQ2 RQ3
        else if (clr_done)
            charge_sample_done_flag <= 1'b0;     // RQ23
    end

    assign link.alert = charge_sample_done_flag;  // RQ3

    // ------------------------------------------------------------------
    // scheduler: pack sum each period, temperatures every eighth
    // ------------------------------------------------------------------
    logic [17:0] cell_total;
    always_comb
    begin
        cell_total = '0;
        for (int i = 0; i < 15; i++)
            cell_total = cell_total + 18'(cell_code[i]);
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            pack_sum_result <= '0;
        else if (sched_tick)                                      // RQ18
            pack_sum_result <= cell_total[`BMS_PACK_SHIFT +: 16]; // RQ13 RQ14
    end

    wire temp_slot = sched_tick
                     && (temp_slot_cnt == 3'(`BMS_TEMP_TICKS - 1)); // RQ17

    always_ff @(posedge clk)
    begin
        if (srst)
            temp_slot_cnt <= '0;
        else if (sched_tick)
            temp_slot_cnt <= temp_slot_cnt + 3'h1;
    end

    // a source change only shows at the next slot, up to 2 s later
    generate
        for (genvar t = 0; t < 3; t++)
        begin : g_temp
            always_ff @(posedge clk)
            begin
                if (srst)
                    temp_result[t] <= '0;
                else if (temp_slot)                      // RQ10
                    temp_result[t] <= temp_sel
                        ? 16'(therm_code[t])             // RQ8 RQ11
                        : 16'(die_code[t]);              // RQ9 RQ12
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // register read path with high/low snapshot
    // ------------------------------------------------------------------
    function automatic bms_byte_t pick(input bms_word_t w,
                                       input logic lo);
        return lo ? w[7:0] : w[15:8];
    endfunction

    bms_word_t sel_word;
    always_comb
    begin
        case (link.addr[7:1])
            `BMS_WORD_CC:    sel_word = cc_result;
            `BMS_WORD_PACK:  sel_word = pack_sum_result;
            `BMS_WORD_TEMP1: sel_word = temp_result[0];
            `BMS_WORD_TEMP2: sel_word = temp_result[1];
            `BMS_WORD_TEMP3: sel_word = temp_result[2];
            default:         sel_word = '0;
        endcase
    end

    wire in_words = (link.addr >= `BMS_REG_CC_HI)
                    && (link.addr <= `BMS_REG_TEMP3LO);
    wire hi_read  = do_read && in_words && !link.addr[0];
    wire use_shad = shadow_ok && (link.addr == shadow_addr);

    bms_byte_t next_rdata;
    always_comb
    begin
        if (link.addr == `BMS_REG_STATUS)
            next_rdata = {7'h00, charge_sample_done_flag};
        else if (link.addr == `BMS_REG_CTRL)
            next_rdata = {5'h00, temp_sel, charge_counter_single_shot,
                          charge_counter_continuous_enable};
        else if (use_shad)
            next_rdata = shadow;                      // RQ21
        else
            next_rdata = pick(sel_word, link.addr[0]);
    end

    // a high read freezes its low partner for the very next access
    always_ff @(posedge clk)
    begin
        if (srst)
            shadow_ok <= 1'b0;
        else if (take)
            shadow_ok <= hi_read;                     // RQ21
    end

    always_ff @(posedge clk)
    begin
        if (hi_read)
        begin
            shadow      <= pick(sel_word, 1'b1);
            shadow_addr <= link.addr + 8'h01;
        end
    end

    // ------------------------------------------------------------------
    // link answer
    // ------------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (srst)
            ack <= 1'b0;
        else
            ack <= take;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            rdata <= '0;
        else if (do_read)
            rdata <= next_rdata;
    end

    assign link.ack   = ack;
    assign link.rdata = rdata;
endmodule
`default_nettype wire

// File: src/bms_host.sv
// host controller end: apb slave that issues link register accesses
`include "bms_defs.svh"
`default_nettype none
module bms_host
    import bms_pkg::*;
(
    input  wire logic        clk,      // system clock
    input  wire logic        srst,     // sync reset
    input  wire logic        psel,     // apb select
    input  wire logic        penable,  // apb access phase
    input  wire logic        pwrite,   // apb direction
    input  wire logic [11:0] paddr,    // apb byte address
    input  wire logic [31:0] pwdata,   // apb write data
    output logic             pready,   // apb ready
    output logic [31:0]      prdata,   // apb read data
    output logic             pslverr,  // apb error, unmapped
    output logic             alert,    // device alert level
    bms_link_if.host         link      // device register link
);
    bms_hstate_t state;
    logic [7:0]  cmd_addr;
    logic [7:0]  cmd_data;
    logic        cmd_wr;
    logic [7:0]  rd_byte;

    wire acc     = psel && penable;
    wire hit_cmd = paddr == `BMS_APB_CMD;
    wire hit_st  = paddr == `BMS_APB_STAT;
    wire busy    = state == BMS_H_WAIT;
    // a command written while busy is dropped; poll busy first
    wire go = acc && pwrite && hit_cmd && pwdata[`BMS_CMD_GO] && !busy;

    assign pready  = 1'b1;
    assign pslverr = acc && !hit_cmd && !hit_st;
    assign prdata  = hit_st
        ? {16'h0000, rd_byte, 6'h00, link.alert, busy}
        : (hit_cmd ? {15'h0000, cmd_wr, cmd_data, cmd_addr} : 32'h0);

    always_ff @(posedge clk)
    begin
        if (srst)
            state <= BMS_H_IDLE;
        else
        begin
            case (state)
                BMS_H_IDLE: if (go) state <= BMS_H_WAIT;
                BMS_H_WAIT: if (link.ack) state <= BMS_H_IDLE;
                default:    state <= BMS_H_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            cmd_addr <= '0;
            cmd_data <= '0;
            cmd_wr   <= 1'b0;
        end
        else if (go)
        begin
            // single shot is only sent with continuous off by software
            cmd_addr <= pwdata[`BMS_CMD_ADDR_LO +: 8];  // RQ5
            cmd_data <= pwdata[`BMS_CMD_DATA_LO +: 8];
            cmd_wr   <= pwdata[`BMS_CMD_WR];
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            rd_byte <= '0;
        else if (busy && link.ack && !cmd_wr)
            rd_byte <= link.rdata;  // RQ15 RQ19 RQ20
    end

    // pack, gain and stack corrections are firmware work on read bytes
    assign link.req   = busy;
    assign link.wr    = cmd_wr;
    assign link.addr  = cmd_addr;
    assign link.wdata = cmd_data;
    assign alert      = link.alert;
endmodule
`default_nettype wire

// File: src/bms_link_if.sv
// register link between host controller and measurement device
`default_nettype none
interface bms_link_if;
    logic       req;    // host request, held until ack
    logic       wr;     // 1 write, 0 read
    logic [7:0] addr;   // register offset
    logic [7:0] wdata;  // write byte
    logic       ack;    // one-cycle answer
    logic [7:0] rdata;  // read byte, valid with ack
    logic       alert;  // conversion done level
    modport dev  (input req, wr, addr, wdata, output ack, rdata, alert);
    modport host (output req, wr, addr, wdata, input ack, rdata, alert);
endinterface
`default_nettype wire

// File: src/bms_pkg.sv
// shared types for the battery measurement scheduler
`default_nettype none
package bms_pkg;
    typedef logic [13:0] bms_code_t;
    typedef logic [7:0]  bms_byte_t;
    typedef logic [15:0] bms_word_t;
    typedef enum logic [0:0]
    {
        BMS_H_IDLE = 1'b0,
        BMS_H_WAIT = 1'b1
    } bms_hstate_t;
endpackage
`default_nettype wire

// File: src/bms_tick.sv
// period counter giving a one-cycle tick at the end of each period
`include "bms_defs.svh"
`default_nettype none
module bms_tick
#(
    parameter int unsigned PERIOD = `BMS_INTEG_CYC
)
(
    input  wire logic clk,   // system clock
    input  wire logic srst,  // sync reset
    input  wire logic en,    // count while high, restart when low
    output logic      tick   // last cycle of period
);
    logic [31:0] cnt;
    wire         at_end = (cnt == 32'(PERIOD - 1));

    assign tick = en && at_end;

    always_ff @(posedge clk)
    begin
        if (srst || !en || at_end)
            cnt <= '0;
        else
            cnt <= cnt + 32'h1;
    end
endmodule
`default_nettype wire

// File: testbench/bms_link_chk.sv
// concurrent checks on the register link between host and device
`include "bms_defs.svh"
`default_nettype none
module bms_link_chk
#(
    parameter int unsigned INTEG_CYC = 16
)
(
    input wire logic       clk,    // system clock
    input wire logic       srst,   // sync reset
    input wire logic       req,    // host request
    input wire logic       wr,     // direction
    input wire logic [7:0] addr,   // register offset
    input wire logic [7:0] wdata,  // write byte
    input wire logic       ack,    // device answer
    input wire logic [7:0] rdata,  // read byte
    input wire logic       alert   // done level
);
    logic [15:0] gap;
    logic        alert_q;
    wire         take  = req && !ack;
    wire         rtake = take && !wr;
    wire         clr   = take && wr && addr == `BMS_REG_STATUS && wdata[0];
    wire         t_hi  = rtake && (addr == 8'h06 || addr == 8'h08
                                   || addr == 8'h0A);

    // cycles since the last rise of the done level, saturating
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            alert_q <= 1'b0;
            gap     <= 16'hFFFF;
        end
        else
        begin
            alert_q <= alert;
            if (alert && !alert_q)
                gap <= 16'h0001;
            else if (gap != 16'hFFFF)
                gap <= gap + 16'h0001;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (srst);

    property p_ack_follows; take |=> ack; endproperty
    a_ack_follows: assert property (p_ack_follows)
        else $error("ack missing after request");
    property p_ack_pulse; ack |=> !ack; endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("ack longer than one cycle");
    property p_req_drop; ack |=> !req; endproperty
    a_req_drop: assert property (p_req_drop)
        else $error("request held after ack");
    property p_req_hold;
        take |=> $stable(addr) && $stable(wr) && $stable(wdata);
    endproperty
    a_req_hold: assert property (p_req_hold)
        else $error("request changed before ack");
    property p_rdata_hold; !rtake |=> $stable(rdata); endproperty
    a_rdata_hold: assert property (p_rdata_hold)
        else $error("read byte changed without a read");
    property p_alert_hold; alert && !clr |=> alert; endproperty
    a_alert_hold: assert property (p_alert_hold)
        else $error("done level fell without a clear");
    property p_alert_gap; $rose(alert) |-> 32'(gap) >= INTEG_CYC; endproperty
    a_alert_gap: assert property (p_alert_gap)
        else $error("conversions closer than one window");
    property p_temp_14; t_hi |=> rdata[7:6] == 2'b00; endproperty
    a_temp_14: assert property (p_temp_14)
        else $error("temperature high byte beyond 14 bits");
endmodule
`default_nettype wire

// File: testbench/testbench.sv
// self-checking bench for the host controller and device pair
`include "bms_defs.svh"
`default_nettype none
module testbench
    import bms_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;
    localparam int INTEG = 16;

    logic             clk;
    logic             srst;
    logic             psel;
    logic             penable;
    logic             pwrite;
    logic [11:0]      paddr;
    logic [31:0]      pwdata;
    logic [31:0]      prdata;
    logic             pready;
    logic             pslverr;
    logic             alert;
    logic             cc_bit;
    bms_code_t [14:0] cell_code;
    bms_code_t [2:0]  therm_code;
    bms_code_t [2:0]  die_code;
    int               failures;
    int               checks_done;
    logic [31:0]      r;
    logic             e;
    bms_byte_t        b;
    logic [15:0]      v;

    bms_link_if bms_link_if_i();
    bms_device #(.INTEG_CYC(INTEG)) bms_device_i
        (.clk(clk), .srst(srst), .link(bms_link_if_i), .cc_bit(cc_bit),
         .cell_code(cell_code), .therm_code(therm_code),
         .die_code(die_code));
    bms_host bms_host_i
        (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
         .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
         .prdata(prdata), .pslverr(pslverr), .alert(alert),
         .link(bms_link_if_i));
    bms_link_chk #(.INTEG_CYC(INTEG)) bms_link_chk_i
        (.clk(clk), .srst(srst), .req(bms_link_if_i.req),
         .wr(bms_link_if_i.wr), .addr(bms_link_if_i.addr),
         .wdata(bms_link_if_i.wdata), .ack(bms_link_if_i.ack),
         .rdata(bms_link_if_i.rdata), .alert(bms_link_if_i.alert));

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic complete_run();
        if (failures == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask

    // one apb transfer; waits for pready however long it takes
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic err);
        @(posedge clk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
            @(posedge clk);
        while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // one link byte: launch, then poll busy until it drops
    task automatic link(input logic w, input bms_byte_t a,
                        input bms_byte_t d, output bms_byte_t q);
        logic [31:0] s;
        logic        x;
        apb(1'b1, `BMS_APB_CMD, {14'h0, 1'b1, w, d, a}, s, x);
        do
            apb(1'b0, `BMS_APB_STAT, 32'h0, s, x);
        while (s[`BMS_STAT_BUSY] !== 1'b0);
        q = s[15:8];
    endtask

    task automatic rd16(input bms_byte_t a, output logic [15:0] q);
        bms_byte_t hi;
        bms_byte_t lo;
        link(1'b0, a, 8'h00, hi);
        link(1'b0, a + 8'h01, 8'h00, lo);
        q = {hi, lo};
    endtask

    task automatic wait_alert();
        int n;
        n = 0;
        while (alert !== 1'b1 && n < 4 * INTEG)
        begin
            @(posedge clk);
            n++;
        end
    endtask

    initial
    begin
        repeat (20000) @(posedge clk);
        failures++;
        complete_run();
    end

    initial
    begin
        srst = 1'b1;
        {psel, penable, pwrite, cc_bit} = 4'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        cell_code = '0;
        therm_code = {14'h3333, 14'h2222, 14'h1111};
        die_code = {14'h0CCC, 14'h0BBB, 14'h0AAA};
        failures = 0;
        checks_done = 0;
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        apb(1'b0, `BMS_APB_STAT, 32'h0, r, e);
        check(r[15:0], 16'h0000);
        link(1'b0, `BMS_REG_CTRL, 8'h00, b);
        check({8'h00, b}, 16'h0000);
        apb(1'b0, 12'h008, 32'h0, r, e);
        check({e, r[14:0]}, 16'h8000);
        // die source until the first temperature interval has passed
        repeat (9 * INTEG) @(posedge clk);
        for (int k = 0; k < 3; k++)
        begin
            rd16(8'h06 + 8'(2 * k), v);
            check(v, {2'b00, die_code[k]});
        end
        link(1'b1, `BMS_REG_CTRL, 8'h04, b);
        // the new source only lands at the next temperature slot
        rd16(8'h06, v);
        check(v, {2'b00, die_code[0]});
        repeat (9 * INTEG) @(posedge clk);
        for (int k = 0; k < 3; k++)
        begin
            rd16(8'h06 + 8'(2 * k), v);
            check(v, {2'b00, therm_code[k]});
        end
        cell_code <= '1;
        repeat (2 * INTEG) @(posedge clk);
        rd16(8'h04, v);
        check(v, 16'hEFFC);
        // pack changes between the two halves of one read
        cell_code <= {{14{14'h0}}, 14'h07FC};
        repeat (2 * INTEG) @(posedge clk);
        link(1'b0, 8'h04, 8'h00, b);
        check({8'h00, b}, 16'h0001);
        cell_code <= {{14{14'h0}}, 14'h0800};
        repeat (3 * INTEG) @(posedge clk);
        link(1'b0, 8'h05, 8'h00, b);
        check({8'h00, b}, 16'h00FF);
        rd16(8'h04, v);
        check(v, 16'h0200);
        // continuous charge with a negative input
        link(1'b1, `BMS_REG_CTRL, 8'h05, b);
        wait_alert();
        check({15'h0, alert}, 16'h0001);
        rd16(`BMS_REG_CC_HI, v);
        check(v, 16'hFFF0);
        repeat (2 * INTEG) @(posedge clk);
        check({15'h0, alert}, 16'h0001);
        link(1'b1, `BMS_REG_STATUS, 8'h01, b);
        wait_alert();
        check({15'h0, alert}, 16'h0001);
        link(1'b1, `BMS_REG_CTRL, 8'h04, b);
        link(1'b1, `BMS_REG_STATUS, 8'h01, b);
        repeat (3 * INTEG) @(posedge clk);
        check({15'h0, alert}, 16'h0000);
        // single shot with a positive input
        cc_bit <= 1'b1;
        link(1'b1, `BMS_REG_CTRL, 8'h06, b);
        apb(1'b0, `BMS_APB_CMD, 32'h0, r, e);
        check(r[31:16], 16'h0001);
        check(r[15:0], 16'h0601);
        wait_alert();
        check({15'h0, alert}, 16'h0001);
        rd16(`BMS_REG_CC_HI, v);
        check(v, 16'h0010);
        link(1'b0, `BMS_REG_CTRL, 8'h00, b);
        check({8'h00, b}, 16'h0004);
        link(1'b1, `BMS_REG_STATUS, 8'h01, b);
        repeat (3 * INTEG) @(posedge clk);
        check({15'h0, alert}, 16'h0000);
        complete_run();
    end
endmodule
`default_nettype wire
